// ---- rtl/tbc_timer.sv ----
// Purpose: 16-bit timer/counter with prescaler, overflow flag and capture timer routing.
// Assumes: Register port with read data one cycle after the read strobe.
// Notes: The block clock is the oscillator clock; the internal count rate is a quarter of it.
//   The count has no reset of its own and reads unknown until software writes it.
//   Unsynchronized external counting trades read coherence for edge latency.
//
// Notes on behaviour
// - Wide-access bit off: bytes accessed independently
// - Capture select routes timers to units
// - Prescale field divides by 1,2,4,8
// - External source: sync bit bypasses synchronizer
// - Internal source ignores sync-disable bit
// - External source counts rising input edges
// - Internal source counts at oscillator/4
// - Counts only while run bit set
// - Count wraps FFFFh to 0000h, sets flag
// - Interrupt request gated by enable bit
// - Low-power oscillator gated by companion enable
// - Special event trigger clears the count
// - Trigger clear never sets overflow flag
// - Count write beats simultaneous trigger
// - Unit one compare value acts as period
// - Count bytes survive non-power resets
// - Control register cleared on power reset
`timescale 1ns/1ps

module tbc_timer
	import tbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic power_rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic ext_clk_in,
	input wire logic lp_osc_clk,
	input wire logic [3:0] unit_one_mode_field,
	input wire logic special_event_trig,
	output logic lp_osc_run,
	output logic unit_one_uses_this_timer,
	output logic unit_two_uses_this_timer,
	output logic [15:0] count_value,
	output logic overflow_irq,
	output logic overflow_irq_priority
);

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] control_r;
	logic [7:0] flags_r;
	logic [7:0] enables_r;
	logic [7:0] priorities_r;
	logic [7:0] companion_r;
	logic [15:0] count_r;
	logic [7:0] high_read_buf_r;
	logic [7:0] high_write_buf_r;
	logic [7:0] reg_rdata_r;
	logic [1:0] instr_div_r;
	logic [2:0] prescale_cnt_r;
	logic ext_sync1_r;
	logic ext_sync2_r;
	logic ext_prev_r;

	logic wide_access;
	logic [1:0] capture_select;
	logic [1:0] prescale_select;
	logic ext_sync_disable;
	logic clock_source_select;
	logic counter_run;
	logic overflow_flag;
	logic overflow_irq_enable;
	logic low_power_osc_enable;

	// ----------------------------------------
	// Control fields
	// ----------------------------------------
	assign wide_access = control_r[TBC_BIT_WIDE_ACCESS];
	assign capture_select = {control_r[TBC_BIT_CAPSEL_HI], control_r[TBC_BIT_CAPSEL_LO]};
	assign prescale_select = control_r[TBC_BIT_PRESCALE_HI:TBC_BIT_PRESCALE_LO];
	assign ext_sync_disable = control_r[TBC_BIT_SYNC_DISABLE];
	assign clock_source_select = control_r[TBC_BIT_CLOCK_SOURCE];
	assign counter_run = control_r[TBC_BIT_COUNTER_RUN];
	assign overflow_flag = flags_r[TBC_BIT_OVERFLOW];
	assign overflow_irq_enable = enables_r[TBC_BIT_OVERFLOW];
	assign low_power_osc_enable = companion_r[TBC_BIT_LP_OSC_ENABLE];

	// ----------------------------------------
	// Functions
	// ----------------------------------------
	function automatic logic [2:0] tbc_prescale_last(input logic [1:0] code);
		case (code)
			TBC_PRESCALE_8: tbc_prescale_last = 3'h7;
			TBC_PRESCALE_4: tbc_prescale_last = 3'h3;
			TBC_PRESCALE_2: tbc_prescale_last = 3'h1;
			default: tbc_prescale_last = 3'h0;
		endcase
	endfunction : tbc_prescale_last

	function automatic logic tbc_hit(input logic [2:0] addr, input logic [2:0] target, input logic stb);
		tbc_hit = stb && (addr == target);
	endfunction : tbc_hit

	// ----------------------------------------
	// Strobe decode
	// ----------------------------------------
	logic wr_control;
	logic wr_low;
	logic wr_high;
	logic wr_flags;
	logic wr_enables;
	logic wr_priorities;
	logic wr_companion;
	logic rd_low;

	assign wr_control = tbc_hit(reg_addr, TBC_ADDR_CONTROL, reg_wr);
	assign wr_low = tbc_hit(reg_addr, TBC_ADDR_COUNT_LOW, reg_wr);
	assign wr_high = tbc_hit(reg_addr, TBC_ADDR_COUNT_HIGH, reg_wr);
	assign wr_flags = tbc_hit(reg_addr, TBC_ADDR_FLAGS_TWO, reg_wr);
	assign wr_enables = tbc_hit(reg_addr, TBC_ADDR_ENABLES_TWO, reg_wr);
	assign wr_priorities = tbc_hit(reg_addr, TBC_ADDR_PRIORITIES_TWO, reg_wr);
	assign wr_companion = tbc_hit(reg_addr, TBC_ADDR_COMPANION_CTRL, reg_wr);
	assign rd_low = tbc_hit(reg_addr, TBC_ADDR_COUNT_LOW, reg_rd);

	// ----------------------------------------
	// Clock source selection
	// ----------------------------------------
	// The low-power oscillator only runs while its enable is set
	logic lp_gated;
	logic ext_source;
	assign lp_osc_run = low_power_osc_enable;
	assign lp_gated = lp_osc_clk & low_power_osc_enable;
	assign ext_source = ext_clk_in | lp_gated;

	// Two-stage synchronizer, then a third stage for edge detection
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ext_sync1_r <= 1'b0;
			ext_sync2_r <= 1'b0;
			ext_prev_r <= 1'b0;
		end else begin
			ext_sync1_r <= ext_source;
			ext_sync2_r <= ext_sync1_r;
			ext_prev_r <= ext_sync2_r;
		end
	end

	// Unsynchronized mode samples the pin once only, so a glitch near the
	// edge may be missed or read mid-update; coherence is not promised.
	logic ext_raw_prev_r;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ext_raw_prev_r <= 1'b0;
		end else begin
			ext_raw_prev_r <= ext_source;
		end
	end

	logic ext_edge;
	assign ext_edge = ext_sync_disable ? (ext_source & ~ext_raw_prev_r)
		: (ext_sync2_r & ~ext_prev_r);

	// Instruction clock divider: one pulse every four system clocks
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			instr_div_r <= 2'h0;
		end else if (instr_div_r == TBC_INSTR_DIV_LAST) begin
			instr_div_r <= 2'h0;
		end else begin
			instr_div_r <= instr_div_r + 2'h1;
		end
	end

	logic instr_tick;
	logic src_tick;
	assign instr_tick = (instr_div_r == TBC_INSTR_DIV_LAST);
	// Sync-disable only matters for the external path
	assign src_tick = clock_source_select ? ext_edge : instr_tick;

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	logic count_tick;
	assign count_tick = counter_run && src_tick
		&& (prescale_cnt_r == tbc_prescale_last(prescale_select));

	always_ff @(posedge core_clk) begin
		if (!nrst || wr_control) begin
			// Clearing on a control write avoids a stale partial count
			prescale_cnt_r <= 3'h0;
		end else if (counter_run && src_tick) begin
			if (prescale_cnt_r >= tbc_prescale_last(prescale_select)) begin
				prescale_cnt_r <= 3'h0;
			end else begin
				prescale_cnt_r <= prescale_cnt_r + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Count register
	// ----------------------------------------
	// The trigger only counts in special-event mode; unit one's compare
	// match thereby sets the period.
	logic trig_clear;
	assign trig_clear = special_event_trig
		&& (unit_one_mode_field == TBC_MODE_SPECIAL_EVENT);

	// In wide mode a high-byte write only fills the buffer and the count
	// keeps running, so it must not hold off an overflow.
	logic count_loaded;
	assign count_loaded = wr_low || (wr_high && !wide_access);
	logic overflow_event;
	assign overflow_event = count_tick && (count_r == TBC_COUNT_MAX) && !trig_clear
		&& !count_loaded;

	// Count is not cleared by the system reset; it only survives it.
	always_ff @(posedge core_clk) begin
		if (wr_low) begin
			if (wide_access) begin
				count_r <= {high_write_buf_r, reg_wdata};
			end else begin
				count_r[7:0] <= reg_wdata;
			end
		end else if (wr_high && !wide_access) begin
			count_r[15:8] <= reg_wdata;
		end else if (trig_clear) begin
			count_r <= 16'h0000;
		end else if (count_tick) begin
			count_r <= count_r + 16'h0001;
		end
	end

	always_ff @(posedge core_clk) begin
		if (wr_high) begin
			high_write_buf_r <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rd_low) begin
			high_read_buf_r <= count_r[15:8];
		end
	end

	// ----------------------------------------
	// Control and interrupt registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (!power_rst_n) begin
			control_r <= TBC_CONTROL_RESET;
		end else if (wr_control) begin
			control_r <= reg_wdata & TBC_CONTROL_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			companion_r <= TBC_COMPANION_RESET;
		end else if (wr_companion) begin
			companion_r <= reg_wdata & TBC_COMPANION_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			flags_r <= TBC_FLAGS_RESET;
		end else if (overflow_event) begin
			flags_r[TBC_BIT_OVERFLOW] <= 1'b1;
		end else if (wr_flags) begin
			// Overflow wins over a same-cycle software write
			flags_r <= reg_wdata & TBC_BIT1_MASK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			enables_r <= TBC_ENABLES_RESET;
			priorities_r <= TBC_PRIORITIES_RESET;
		end else begin
			if (wr_enables) begin
				enables_r <= reg_wdata & TBC_BIT1_MASK;
			end
			if (wr_priorities) begin
				priorities_r <= reg_wdata & TBC_BIT1_MASK;
			end
		end
	end

	// ----------------------------------------
	// Interrupt outputs
	// ----------------------------------------
	assign overflow_irq = overflow_flag & overflow_irq_enable;
	assign overflow_irq_priority = priorities_r[TBC_BIT_OVERFLOW];

	// ----------------------------------------
	// Capture timer routing
	// ----------------------------------------
	// Code 01 leaves unit one on the other timer
	assign unit_one_uses_this_timer = capture_select[1];
	assign unit_two_uses_this_timer = capture_select[1] | capture_select[0];
	assign count_value = count_r;

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	// Data stands one cycle only, so idle cycles read as zero
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reg_rdata_r <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == TBC_ADDR_CONTROL) begin
				reg_rdata_r <= control_r;
			end else if (reg_addr == TBC_ADDR_COUNT_LOW) begin
				reg_rdata_r <= count_r[7:0];
			end else if (reg_addr == TBC_ADDR_COUNT_HIGH) begin
				reg_rdata_r <= wide_access ? high_read_buf_r : count_r[15:8];
			end else if (reg_addr == TBC_ADDR_FLAGS_TWO) begin
				reg_rdata_r <= flags_r;
			end else if (reg_addr == TBC_ADDR_ENABLES_TWO) begin
				reg_rdata_r <= enables_r;
			end else if (reg_addr == TBC_ADDR_PRIORITIES_TWO) begin
				reg_rdata_r <= priorities_r;
			end else if (reg_addr == TBC_ADDR_COMPANION_CTRL) begin
				reg_rdata_r <= companion_r;
			end else begin
				reg_rdata_r <= 8'h00;
			end
		end else begin
			reg_rdata_r <= 8'h00;
		end
	end

	assign reg_rdata = reg_rdata_r;

endmodule : tbc_timer

// ---- rtl/tbc_pkg.sv ----
// Purpose: Constants for the timer-b counter block.
// Assumes: Byte-wide register port, one system clock.
// Notes: Register offsets are local to this block.
package tbc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] TBC_ADDR_CONTROL = 3'h0;
	localparam logic [2:0] TBC_ADDR_COUNT_LOW = 3'h1;
	localparam logic [2:0] TBC_ADDR_COUNT_HIGH = 3'h2;
	localparam logic [2:0] TBC_ADDR_FLAGS_TWO = 3'h3;
	localparam logic [2:0] TBC_ADDR_ENABLES_TWO = 3'h4;
	localparam logic [2:0] TBC_ADDR_PRIORITIES_TWO = 3'h5;
	localparam logic [2:0] TBC_ADDR_COMPANION_CTRL = 3'h6;

	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int TBC_BIT_WIDE_ACCESS = 7;
	localparam int TBC_BIT_CAPSEL_HI = 6;
	localparam int TBC_BIT_PRESCALE_HI = 5;
	localparam int TBC_BIT_PRESCALE_LO = 4;
	localparam int TBC_BIT_CAPSEL_LO = 3;
	localparam int TBC_BIT_SYNC_DISABLE = 2;
	localparam int TBC_BIT_CLOCK_SOURCE = 1;
	localparam int TBC_BIT_COUNTER_RUN = 0;
	localparam int TBC_BIT_OVERFLOW = 1;
	localparam int TBC_BIT_LP_OSC_ENABLE = 3;

	// ----------------------------------------
	// Reset values and masks
	// ----------------------------------------
	localparam logic [7:0] TBC_CONTROL_RESET = 8'h00;
	localparam logic [7:0] TBC_FLAGS_RESET = 8'h00;
	localparam logic [7:0] TBC_ENABLES_RESET = 8'h00;
	localparam logic [7:0] TBC_PRIORITIES_RESET = 8'h00;
	localparam logic [7:0] TBC_COMPANION_RESET = 8'h00;
	localparam logic [7:0] TBC_CONTROL_MASK = 8'hFF;
	localparam logic [7:0] TBC_BIT1_MASK = 8'h02;
	localparam logic [7:0] TBC_COMPANION_MASK = 8'h08;
	localparam logic [3:0] TBC_MODE_SPECIAL_EVENT = 4'hB;
	localparam logic [15:0] TBC_COUNT_MAX = 16'hFFFF;

	// ----------------------------------------
	// Timing: instruction clock is a quarter of the system clock
	// ----------------------------------------
	localparam int TBC_INSTR_CLK_DIV = 4;
	localparam logic [1:0] TBC_INSTR_DIV_LAST = 2'(TBC_INSTR_CLK_DIV - 1);

	// ----------------------------------------
	// Prescale codes
	// ----------------------------------------
	localparam logic [1:0] TBC_PRESCALE_1 = 2'h0;
	localparam logic [1:0] TBC_PRESCALE_2 = 2'h1;
	localparam logic [1:0] TBC_PRESCALE_4 = 2'h2;
	localparam logic [1:0] TBC_PRESCALE_8 = 2'h3;
endpackage : tbc_pkg

// ---- bench/tbc_timer_assertions.sv ----
// Purpose: Port checks for the timer-b counter.
// Assumes: Both resets synchronous, active low.
// Notes: Count is unknown until software writes it.
`timescale 1ns/1ps
module tbc_chk
	import tbc_pkg::*;
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic power_rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic ext_clk_in,
	input wire logic lp_osc_clk,
	input wire logic [3:0] unit_one_mode_field,
	input wire logic special_event_trig,
	input wire logic lp_osc_run,
	input wire logic unit_one_uses_this_timer,
	input wire logic unit_two_uses_this_timer,
	input wire logic [15:0] count_value,
	input wire logic overflow_irq,
	input wire logic overflow_irq_priority
);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst || !power_rst_n);
	logic trig_on;
	logic ctl_wr;
	assign trig_on = special_event_trig && unit_one_mode_field == TBC_MODE_SPECIAL_EVENT;
	assign ctl_wr = reg_wr && reg_addr == TBC_ADDR_CONTROL;
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside slot");
	a_route_write: assert property (ctl_wr |=> unit_one_uses_this_timer == $past(reg_wdata[6])
		&& unit_two_uses_this_timer == ($past(reg_wdata[6]) | $past(reg_wdata[3])))
		else $error("capture routing wrong");
	a_trig_clear: assert property (trig_on && !reg_wr |=> count_value == 16'h0000)
		else $error("trigger did not clear");
	a_write_wins: assert property (trig_on && reg_wr && reg_addr == TBC_ADDR_COUNT_LOW
		|=> count_value[7:0] == $past(reg_wdata)) else $error("write lost to trigger");
	a_irq_wrap: assert property ($rose(overflow_irq) && !$past(reg_wr) |-> count_value == 16'h0000)
		else $error("irq without wrap");
	a_lp_osc: assert property (reg_wr && reg_addr == TBC_ADDR_COMPANION_CTRL
		|=> lp_osc_run == $past(reg_wdata[TBC_BIT_LP_OSC_ENABLE])) else $error("osc enable wrong");
	a_count_step: assert property (!$past(reg_wr) && !$past(special_event_trig)
		&& count_value != $past(count_value) |-> count_value == $past(count_value) + 16'h0001)
		else $error("count jumped");
	// Fastest legal source gives at least four cycles between steps
	a_count_rate: assert property (count_value == $past(count_value) + 16'h0001 && !$past(reg_wr)
		&& !$past(special_event_trig) |=> (count_value == $past(count_value) || $past(reg_wr)
		|| $past(special_event_trig)) [*3]) else $error("count too fast");
	c_trig: cover property (trig_on ##1 count_value == 16'h0000);
	c_irq: cover property ($rose(overflow_irq));
	c_route: cover property (unit_two_uses_this_timer && !unit_one_uses_this_timer);
endmodule : tbc_chk

bind tbc_timer tbc_chk u_chk (
	.core_clk(core_clk),
	.nrst(nrst),
	.power_rst_n(power_rst_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.ext_clk_in(ext_clk_in),
	.lp_osc_clk(lp_osc_clk),
	.unit_one_mode_field(unit_one_mode_field),
	.special_event_trig(special_event_trig),
	.lp_osc_run(lp_osc_run),
	.unit_one_uses_this_timer(unit_one_uses_this_timer),
	.unit_two_uses_this_timer(unit_two_uses_this_timer),
	.count_value(count_value),
	.overflow_irq(overflow_irq),
	.overflow_irq_priority(overflow_irq_priority)
);

// ---- bench/tbc_far_end.sv ----
// Purpose: Clock inputs and unit-one trigger source.
// Assumes: Edges last four cycles high, four low.
// Notes: Lines rest low between pulses.
`timescale 1ns/1ps
module tbc_far_end
	import tbc_pkg::*;
(
	input wire logic core_clk,
	output logic ext_clk_in,
	output logic lp_osc_clk,
	output logic [3:0] unit_one_mode_field,
	output logic special_event_trig
);
	initial begin
		ext_clk_in = 1'h0;
		lp_osc_clk = 1'h0;
		unit_one_mode_field = 4'h0;
		special_event_trig = 1'h0;
	end
	task automatic pulses(input int n, input logic lp);
		repeat (n) begin
			@(posedge core_clk);
			ext_clk_in <= !lp;
			lp_osc_clk <= lp;
			repeat (4) @(posedge core_clk);
			ext_clk_in <= 1'h0;
			lp_osc_clk <= 1'h0;
			repeat (3) @(posedge core_clk);
		end
	endtask : pulses
	task automatic fire(input logic [3:0] m);
		@(posedge core_clk);
		unit_one_mode_field <= m;
		special_event_trig <= 1'h1;
		@(posedge core_clk);
		special_event_trig <= 1'h0;
		@(negedge core_clk);
	endtask : fire
endmodule : tbc_far_end

// ---- bench/tbc_timer_tb_top.sv ----
// Purpose: Self-checking bench for the timer-b counter.
// Assumes: Register port answers one cycle after a read.
// Notes: Count is written before any count check.
`timescale 1ns/1ps
module tbc_timer_tb_top import tbc_pkg::*;;
	logic core_clk = 1'h0;
	logic nrst = 1'h0;
	logic power_rst_n = 1'h0;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic [15:0] rv;
	logic ext_clk_in, lp_osc_clk, special_event_trig, lp_osc_run, overflow_irq;
	logic unit_one_uses_this_timer, unit_two_uses_this_timer, overflow_irq_priority;
	logic [3:0] unit_one_mode_field;
	logic [15:0] count_value;
	int fail_count = 0;
	int num_checks = 0;
	always #25 core_clk = ~core_clk;
	tbc_timer dut (
		.core_clk(core_clk),
		.nrst(nrst),
		.power_rst_n(power_rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.ext_clk_in(ext_clk_in),
		.lp_osc_clk(lp_osc_clk),
		.unit_one_mode_field(unit_one_mode_field),
		.special_event_trig(special_event_trig),
		.lp_osc_run(lp_osc_run),
		.unit_one_uses_this_timer(unit_one_uses_this_timer),
		.unit_two_uses_this_timer(unit_two_uses_this_timer),
		.count_value(count_value),
		.overflow_irq(overflow_irq),
		.overflow_irq_priority(overflow_irq_priority)
	);
	tbc_far_end far (
		.core_clk(core_clk),
		.ext_clk_in(ext_clk_in),
		.lp_osc_clk(lp_osc_clk),
		.unit_one_mode_field(unit_one_mode_field),
		.special_event_trig(special_event_trig)
	);
	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
		@(negedge core_clk);
	endtask : wr
	task automatic rd(input logic [2:0] a);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(negedge core_clk);
		rv = {8'h00, reg_rdata};
	endtask : rd
	task automatic setc(input logic [7:0] c, input logic [15:0] v);
		wr(TBC_ADDR_CONTROL, 8'h00);
		wr(TBC_ADDR_COUNT_LOW, v[7:0]);
		wr(TBC_ADDR_COUNT_HIGH, v[15:8]);
		wr(TBC_ADDR_CONTROL, c);
	endtask : setc
	task automatic results();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : results
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs();
		for (int a = 0; a < 8; a++) begin
			if (a == 7)
				wr(3'h7, 8'hFF);
			if (a != 1 && a != 2) begin
				rd(3'(a));
				chk("reset reg", 16'h0000, rv);
			end
		end
		$display("register reset test done");
	endtask : t_regs
	task automatic t_bytes();
		setc(8'h00, 16'h3CA5);
		repeat (20) @(negedge core_clk);
		chk("held count", 16'h3CA5, count_value);
		rd(TBC_ADDR_COUNT_HIGH);
		chk("high byte", 16'h003C, rv);
		wr(TBC_ADDR_CONTROL, 8'h80);
		wr(TBC_ADDR_COUNT_HIGH, 8'h12);
		chk("buffered high", 16'h3CA5, count_value);
		wr(TBC_ADDR_COUNT_LOW, 8'h34);
		chk("wide write", 16'h1234, count_value);
		rd(TBC_ADDR_COUNT_LOW);
		chk("wide low", 16'h0034, rv);
		wr(TBC_ADDR_COUNT_HIGH, 8'h56);
		wr(TBC_ADDR_COUNT_LOW, 8'h78);
		rd(TBC_ADDR_COUNT_HIGH);
		chk("latched high", 16'h0012, rv);
		chk("second wide write", 16'h5678, count_value);
		$display("byte access test done");
	endtask : t_bytes
	task automatic t_scale();
		for (int p = 0; p < 4; p++) begin
			setc(8'(p << 4) | (p == 3 ? 8'h05 : 8'h01), 16'h0000);
			repeat (32 << p) @(posedge core_clk);
			wr(TBC_ADDR_CONTROL, 8'h00);
			chk("scaled", 16'h0008, (count_value > 6 && count_value < 10) ? 16'h0008 : count_value);
		end
		$display("prescale test done");
	endtask : t_scale
	task automatic t_ovf();
		wr(TBC_ADDR_ENABLES_TWO, 8'h02);
		setc(8'h01, 16'hFFFE);
		repeat (12) @(posedge core_clk);
		wr(TBC_ADDR_CONTROL, 8'h00);
		chk("irq", 16'h0001, 16'(overflow_irq));
		wr(TBC_ADDR_ENABLES_TWO, 8'h00);
		chk("masked irq", 16'h0000, 16'(overflow_irq));
		rd(TBC_ADDR_FLAGS_TWO);
		chk("flag", 16'h0002, rv);
		wr(TBC_ADDR_FLAGS_TWO, 8'h00);
		wr(TBC_ADDR_ENABLES_TWO, 8'h02);
		wr(TBC_ADDR_PRIORITIES_TWO, 8'h02);
		chk("priority", 16'h0001, 16'(overflow_irq_priority));
		rd(TBC_ADDR_PRIORITIES_TWO);
		chk("priority reg", 16'h0002, rv);
		$display("overflow test done");
	endtask : t_ovf
	task automatic t_ext();
		setc(8'h03, 16'h0000);
		far.pulses(5, 1'h0);
		repeat (6) @(negedge core_clk);
		chk("sync count", 16'h0005, count_value);
		wr(TBC_ADDR_CONTROL, 8'h07);
		far.pulses(3, 1'h0);
		repeat (6) @(negedge core_clk);
		chk("async count", 16'h0008, count_value);
		for (int e = 1; e >= 0; e--) begin
			wr(TBC_ADDR_COMPANION_CTRL, 8'(e << 3));
			chk("osc run", 16'(e), 16'(lp_osc_run));
			far.pulses(2, 1'h1);
			repeat (6) @(negedge core_clk);
			chk("osc count", 16'h000A, count_value);
		end
		$display("external clock test done");
	endtask : t_ext
	task automatic t_trig();
		setc(8'h00, 16'hFFFF);
		far.fire(4'hA);
		chk("other mode", 16'hFFFF, count_value);
		far.fire(TBC_MODE_SPECIAL_EVENT);
		chk("trig clear", 16'h0000, count_value);
		chk("trig irq", 16'h0000, 16'(overflow_irq));
		fork
			wr(TBC_ADDR_COUNT_LOW, 8'h55);
			far.fire(TBC_MODE_SPECIAL_EVENT);
		join
		chk("write wins", 16'h0055, count_value);
		$display("trigger test done");
	endtask : t_trig
	task automatic t_route();
		for (int c = 0; c < 4; c++) begin
			wr(TBC_ADDR_CONTROL, {1'h0, c[1], 2'h0, c[0], 3'h0});
			chk("unit one", 16'(c[1]), 16'(unit_one_uses_this_timer));
			chk("unit two", 16'(c != 0), 16'(unit_two_uses_this_timer));
		end
		$display("routing test done");
	endtask : t_route
	task automatic t_rst();
		wr(TBC_ADDR_CONTROL, 8'h5A);
		@(posedge core_clk);
		nrst <= 1'h0;
		repeat (2) @(posedge core_clk);
		nrst <= 1'h1;
		@(negedge core_clk);
		chk("kept count", 16'h0055, count_value);
		rd(TBC_ADDR_CONTROL);
		chk("kept control", 16'h005A, rv);
		rd(TBC_ADDR_ENABLES_TWO);
		chk("reset enables", 16'h0000, rv);
		@(posedge core_clk);
		power_rst_n <= 1'h0;
		repeat (2) @(posedge core_clk);
		power_rst_n <= 1'h1;
		rd(TBC_ADDR_CONTROL);
		chk("power control", 16'h0000, rv);
		$display("reset test done");
	endtask : t_rst
	initial begin
		repeat (6) @(posedge core_clk);
		nrst <= 1'h1;
		power_rst_n <= 1'h1;
		t_regs();
		t_bytes();
		t_scale();
		t_ovf();
		t_ext();
		t_trig();
		t_route();
		t_rst();
		results();
	end
	// Whole run needs under a thousand cycles
	initial begin
		#2000000;
		fail_count++;
		results();
	end
endmodule : tbc_timer_tb_top
